// file: inc/sfr_pkg.sv
package sfr_pkg;

   // Register addresses seen by the host
   localparam logic [7:0] SFR_ADDR_LEVEL     = 8'hfd;
   localparam logic [7:0] SFR_ADDR_DATA_LOW  = 8'hfe;
   localparam logic [7:0] SFR_ADDR_DATA_HIGH = 8'hff;

   // Storage geometry
   localparam int         SFR_RAM_BYTES      = 256;
   localparam int         SFR_ENTRY_BYTES    = 2;
   localparam int         SFR_CHANNELS       = 6;

   // Reset and idle values
   localparam logic [7:0] SFR_ZERO_BYTE      = 8'h00;
   localparam logic [7:0] SFR_PTR_RESET      = 8'h00;
   localparam logic [7:0] SFR_LNK_PTR_RESET  = 8'hfe;

   // Read request carried from the link domain into the core domain
   typedef struct packed {
      logic       tgl;
      logic [7:0] addr;
   } sfr_req_type;

   // Answer carried back to the link domain
   typedef struct packed {
      logic       tgl;
      logic [7:0] data;
   } sfr_resp_type;

   typedef enum logic {SFR_IDLE, SFR_PUSH} sfr_state_type;

endpackage : sfr_pkg

// file: logic/sfr_fifo_top.sv
// Notes on behaviour
// RL1: Results live in a 256-byte store read as up to 128 two-byte entries.
// RL2: A push into a full store sets the overflow flag and drops the byte.
// RL3: The host gets results only by reading the two data addresses.
// RL4: Sequential reads wrap the address pointer from the high to low slot.
// RL5: Single-byte reads and bursts of any length are both served.
// RL6: Only a read of the high data address consumes an entry.
// RL7: In a burst each completed two-byte entry consumes one entry.
// RL8: Data reads with no entry left return zero.
// RL9: The data interrupt is high while at least one entry is unread.
// RL10: The fill level of unread entries is readable by the host.
// RL11: Each selected channel pushes its result as two bytes per sample.
// RL12: With status capture on, the analog status pushes one byte per sample.
// RL13: The fill level counts two-byte entries from zero up to 128.
// RL14: Reads on an empty store leave pointer and level untouched.
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo_top
   import sfr_pkg::*;
#(
   parameter int RAM_BYTES = SFR_RAM_BYTES,
   parameter int CHANNELS  = SFR_CHANNELS
)
(
   // Core clock, reset and enable
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     clk_en_i,
   // Measurement results from the sensor core
   input  wire logic                     smp_valid_i,
   input  wire logic [CHANNELS-1:0][15:0] smp_data_i,
   input  wire logic [CHANNELS-1:0]      channel_capture_select_i,
   input  wire logic                     status_capture_en_i,
   input  wire logic [7:0]               analog_status_byte_i,
   output logic                          smp_ready_o,
   // Status seen by the rest of the device
   input  wire logic                     overflow_clear_i,
   output logic                          overflow_o,
   output logic [7:0]                    fifo_fill_level_o,
   output logic                          fifo_data_interrupt_o,
   // Host register port on the link clock
   input  wire logic                     lnk_clk_i,
   input  wire logic                     lnk_addr_set_i,
   input  wire logic [7:0]               lnk_addr_i,
   input  wire logic                     lnk_rd_i,
   output logic      [7:0]               lnk_rd_data_o,
   output logic                          lnk_rd_valid_o,
   output logic                          lnk_busy_o
);

   // Two byte slots per channel plus one for the status byte
   localparam int SLOTS = 2 * CHANNELS + 1;
   // Byte count must hold the full value, one past the last index
   localparam int CW    = $clog2(RAM_BYTES + 1);
   // Pointers wrap on their own, so the store size is a power of two
   localparam int PW    = $clog2(RAM_BYTES);

   // Byte store and its pointers, all in flip-flops
   logic [7:0]       mem [RAM_BYTES];
   logic [7:0]       next_mem [RAM_BYTES];
   logic [PW-1:0]    wr_ptr;
   logic [PW-1:0]    next_wr_ptr;
   logic [PW-1:0]    rd_ptr;
   logic [PW-1:0]    next_rd_ptr;
   logic [CW-1:0]    byte_cnt;
   logic [CW-1:0]    next_byte_cnt;
   logic             next_overflow;
   logic [7:0]       next_level;

   // Sample unpacking
   sfr_state_type    state;
   sfr_state_type    next_state;
   logic [SLOTS-1:0] pend;
   logic [SLOTS-1:0] next_pend;
   logic [7:0]       smp_bytes [SLOTS];
   logic [7:0]       next_smp_bytes [SLOTS];
   logic             push_en;
   logic [7:0]       push_byte;

   // Crossing and read answer; the toggles carry the handshake and the
   // words ride along while they are held
   sfr_req_type      lnk_req;
   sfr_resp_type     resp;
   sfr_resp_type     next_resp;
   logic             req_sync;
   logic             req_seen;
   logic             next_req_seen;
   logic             req_new;
   logic [CW-1:0]    entries;

   // Link facing port on its own clock. It keeps the address pointer
   // itself, so the wrap in a burst costs no round trip through the
   // core domain.
   sfr_link_port u_link (
      .lnk_clk_i      (lnk_clk_i),
      .rst_i          (rst_i),
      .lnk_addr_set_i (lnk_addr_set_i),
      .lnk_addr_i     (lnk_addr_i),
      .lnk_rd_i       (lnk_rd_i),
      .lnk_rd_data_o  (lnk_rd_data_o),
      .lnk_rd_valid_o (lnk_rd_valid_o),
      .lnk_busy_o     (lnk_busy_o),
      .req_o          (lnk_req),
      .resp_i         (resp)
   );

   // Request toggle crosses; its address is held stable by the link side
   // until the answer returns, so the address word needs no synchroniser
   sfr_sync #(.W(1)) u_req_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .d_i   (lnk_req.tgl),
      .q_o   (req_sync)
   );

   // A new request shows as a toggle not yet served
   assign req_new = (req_sync != req_seen);
   // RL13: level counts whole entries
   // An odd status byte stays out of the level until its partner lands
   assign entries = byte_cnt >> 1;

   // Sample unpacking: one byte per cycle, lowest pending slot first.
   // One byte per cycle keeps a single write port on the store; the cost
   // is that ready stays low for one cycle per selected byte, and for one cycle when none is selected.
   always_comb
   begin
      next_state     = state;
      next_pend      = pend;
      next_smp_bytes = smp_bytes;
      push_en        = 1'b0;
      push_byte      = SFR_ZERO_BYTE;
      case (state)
         SFR_IDLE:
         begin
            // A set offered while pushing is not taken; the source waits
            if (smp_valid_i)
            begin
               for (int c = 0; c < CHANNELS; c++)
               begin
                  // RL11: two bytes per channel
                  next_pend[2*c]        = channel_capture_select_i[c];
                  next_pend[2*c+1]      = channel_capture_select_i[c];
                  next_smp_bytes[2*c]   = smp_data_i[c][7:0];
                  next_smp_bytes[2*c+1] = smp_data_i[c][15:8];
               end
               // RL12: one status byte
               next_pend[SLOTS-1]      = status_capture_en_i;
               next_smp_bytes[SLOTS-1] = analog_status_byte_i;
               next_state              = SFR_PUSH;
            end
         end
         SFR_PUSH:
         begin
            // Scan high to low so the last hit is the lowest slot
            for (int s = SLOTS - 1; s >= 0; s--)
            begin
               if (pend[s])
               begin
                  push_en   = 1'b1;
                  push_byte = smp_bytes[s];
               end
            end
            // Clear only the slot pushed in this cycle
            for (int s = 0; s < SLOTS; s++)
            begin
               if (pend[s] && !(|(pend & ((SLOTS'(1) << s) - SLOTS'(1)))))
                  next_pend[s] = 1'b0;
            end
            if (next_pend == '0)
               next_state = SFR_IDLE;
         end
         default:
            next_state = SFR_IDLE;
      endcase
   end

   // Store, pointers, flags and host read answers
   always_comb
   begin
      next_mem      = mem;
      next_wr_ptr   = wr_ptr;
      next_rd_ptr   = rd_ptr;
      next_byte_cnt = byte_cnt;
      next_overflow = overflow_o;
      next_resp     = resp;
      next_req_seen = req_seen;
      // Clear first; an overflow in the same cycle sets it again below
      if (overflow_clear_i)
         next_overflow = 1'b0;
      // RL3: only the data addresses hand out stored bytes
      if (req_new)
      begin
         // The answer toggle flips once per request, so the link side
         // sees one answer per read however long clock enable stalls
         next_req_seen  = req_sync;
         next_resp.tgl  = ~resp.tgl;
         // RL8: empty reads give zero
         next_resp.data = SFR_ZERO_BYTE;
         if (lnk_req.addr == SFR_ADDR_LEVEL)
         begin
            // RL10: level readable
            next_resp.data = 8'(entries);
         end
         // RL14: empty leaves state alone
         else if (entries != '0)
         begin
            // RL5: any read pattern works byte by byte
            if (lnk_req.addr == SFR_ADDR_DATA_LOW)
               next_resp.data = mem[rd_ptr];
            else if (lnk_req.addr == SFR_ADDR_DATA_HIGH)
            begin
               next_resp.data = mem[PW'(rd_ptr + PW'(1))];
               // RL6: high byte consumes
               // RL7: one pop per entry
               next_rd_ptr   = PW'(rd_ptr + PW'(SFR_ENTRY_BYTES));
               next_byte_cnt = CW'(next_byte_cnt - CW'(SFR_ENTRY_BYTES));
            end
         end
      end
      if (push_en)
      begin
         // RL2: full drops and flags
         // Checked after this cycle's pop, so a pop and a push that meet
         // on a full store keep the new byte
         if (next_byte_cnt == CW'(RAM_BYTES))
            next_overflow = 1'b1;
         else
         begin
            // RL1: byte store
            // Bytes go straight into the flop store, no staging buffer
            next_mem[wr_ptr] = push_byte;
            next_wr_ptr      = PW'(wr_ptr + PW'(1));
            next_byte_cnt    = CW'(next_byte_cnt + CW'(1));
         end
      end
      // Level follows the next count, so it moves on the store's edge
      next_level = 8'(next_byte_cnt >> 1);
   end

   // Unpacker state; clock enable low freezes the core domain
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state       <= SFR_IDLE;
         pend        <= '0;
         smp_bytes   <= '{default: SFR_ZERO_BYTE};
         smp_ready_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         state       <= next_state;
         pend        <= next_pend;
         smp_bytes   <= next_smp_bytes;
         // Ready mirrors the next state so it never lags the unpacker
         smp_ready_o <= (next_state == SFR_IDLE);
      end
   end

   // Store and pointers; the contents get a reset too, so a read of a
   // slot never written is defined
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         mem      <= '{default: SFR_ZERO_BYTE};
         wr_ptr   <= '0;
         rd_ptr   <= '0;
         byte_cnt <= '0;
      end
      else if (clk_en_i)
      begin
         mem      <= next_mem;
         wr_ptr   <= next_wr_ptr;
         rd_ptr   <= next_rd_ptr;
         byte_cnt <= next_byte_cnt;
      end
   end

   // Flags, level and host answers; a stalled enable only delays answers
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         overflow_o            <= 1'b0;
         resp                  <= '0;
         req_seen              <= 1'b0;
         fifo_fill_level_o     <= SFR_PTR_RESET;
         fifo_data_interrupt_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         overflow_o            <= next_overflow;
         resp                  <= next_resp;
         req_seen              <= next_req_seen;
         fifo_fill_level_o     <= next_level;
         // RL9: interrupt while data waits
         fifo_data_interrupt_o <= (next_level != SFR_ZERO_BYTE);
      end
   end

endmodule : sfr_fifo_top
`default_nettype wire

// file: logic/sfr_link_port.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_link_port
   import sfr_pkg::*;
(
   // Link clock and reset
   input  wire logic         lnk_clk_i,
   input  wire logic         rst_i,
   // Host side byte port
   input  wire logic         lnk_addr_set_i,
   input  wire logic [7:0]   lnk_addr_i,
   input  wire logic         lnk_rd_i,
   output logic      [7:0]   lnk_rd_data_o,
   output logic              lnk_rd_valid_o,
   output logic              lnk_busy_o,
   // Crossing to and from the core domain
   output var sfr_req_type   req_o,
   input  wire sfr_resp_type resp_i
);

   logic [7:0]  ptr;
   logic [7:0]  next_ptr;
   logic        ack_seen;
   logic        ack_sync;
   logic        next_ack_seen;
   sfr_req_type next_req;
   logic [7:0]  next_rd_data;
   logic        next_rd_valid;
   logic        next_busy;

   // Answer toggle passes two flops; data is stable once it flips
   sfr_sync #(.W(1)) u_ack_sync (
      .clk_i (lnk_clk_i),
      .rst_i (rst_i),
      .d_i   (resp_i.tgl),
      .q_o   (ack_sync)
   );

   // Address pointer, request launch and answer capture
   always_comb
   begin
      next_ptr      = ptr;
      next_req      = req_o;
      next_rd_data  = lnk_rd_data_o;
      next_rd_valid = 1'b0;
      next_busy     = lnk_busy_o;
      next_ack_seen = ack_seen;
      if (lnk_busy_o && (ack_sync != ack_seen))
      begin
         next_ack_seen = ack_sync;
         next_rd_data  = resp_i.data;
         next_rd_valid = 1'b1;
         next_busy     = 1'b0;
      end
      else if (!lnk_busy_o && lnk_addr_set_i)
      begin
         next_ptr = lnk_addr_i;
      end
      else if (!lnk_busy_o && lnk_rd_i)
      begin
         // Address held stable until the answer returns
         next_req.addr = ptr;
         next_req.tgl  = ~req_o.tgl;
         next_busy     = 1'b1;
         // RL4: pointer wraps back
         if (ptr == SFR_ADDR_DATA_HIGH)
            next_ptr = SFR_ADDR_DATA_LOW;
         else
            next_ptr = 8'(ptr + 8'h01);
      end
   end

   always_ff @(posedge lnk_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         ptr            <= SFR_LNK_PTR_RESET;
         req_o          <= '0;
         lnk_rd_data_o  <= SFR_ZERO_BYTE;
         lnk_rd_valid_o <= 1'b0;
         lnk_busy_o     <= 1'b0;
         ack_seen       <= 1'b0;
      end
      else
      begin
         ptr            <= next_ptr;
         req_o          <= next_req;
         lnk_rd_data_o  <= next_rd_data;
         lnk_rd_valid_o <= next_rd_valid;
         lnk_busy_o     <= next_busy;
         ack_seen       <= next_ack_seen;
      end
   end

endmodule : sfr_link_port
`default_nettype wire

// file: logic/sfr_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_sync
   import sfr_pkg::*;
#(
   parameter int W = 1
)
(
   // Clock and reset of the receiving domain
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // Level from the other domain and its synchronised copy
   input  wire logic [W-1:0] d_i,
   output logic      [W-1:0] q_o
);

   logic [W-1:0] meta;
   logic [W-1:0] next_meta;

   // First stage feeds only the second stage
   always_comb
   begin
      next_meta = d_i;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else
      begin
         meta <= next_meta;
         q_o  <= meta;
      end
   end

endmodule : sfr_sync
`default_nettype wire

// file: verification/sfr_fifo_properties.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_fifo_properties
#(
   parameter int RAM_BYTES = 256
)
(
   // Core domain
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       clk_en_i,
   input wire logic       smp_valid_i,
   input wire logic       smp_ready_o,
   input wire logic       overflow_clear_i,
   input wire logic       overflow_o,
   input wire logic [7:0] fifo_fill_level_o,
   input wire logic       fifo_data_interrupt_o,
   // Link domain
   input wire logic       lnk_clk_i,
   input wire logic       lnk_addr_set_i,
   input wire logic       lnk_rd_i,
   input wire logic       lnk_rd_valid_o,
   input wire logic       lnk_busy_o
);
   localparam int LVL_MAX = RAM_BYTES / 2;
   // Core domain relations
   property p_int;
      @(posedge clk_i) disable iff (rst_i)
      fifo_data_interrupt_o == (fifo_fill_level_o != 8'h00);
   endproperty
   property p_max;
      @(posedge clk_i) disable iff (rst_i) fifo_fill_level_o <= LVL_MAX;
   endproperty
   // At most one entry completes or leaves per cycle
   property p_step;
      @(posedge clk_i) disable iff (rst_i)
      fifo_fill_level_o <= $past(fifo_fill_level_o) + 8'h01 &&
      $past(fifo_fill_level_o) <= fifo_fill_level_o + 8'h01;
   endproperty
   property p_ovf_full;
      @(posedge clk_i) disable iff (rst_i)
      $rose(overflow_o) |-> fifo_fill_level_o == LVL_MAX;
   endproperty
   property p_ovf_hold;
      @(posedge clk_i) disable iff (rst_i)
      overflow_o && !overflow_clear_i |=> overflow_o;
   endproperty
   property p_take;
      @(posedge clk_i) disable iff (rst_i)
      smp_valid_i && smp_ready_o && clk_en_i |=> !smp_ready_o;
   endproperty
   // Only a push can lift an empty store
   property p_empty;
      @(posedge clk_i) disable iff (rst_i)
      smp_ready_o && !(smp_valid_i && clk_en_i) &&
      fifo_fill_level_o == 8'h00 |=> fifo_fill_level_o == 8'h00;
   endproperty
   // Link domain relations
   property p_busy;
      @(posedge lnk_clk_i) disable iff (rst_i)
      lnk_rd_i && !lnk_busy_o && !lnk_addr_set_i |=> lnk_busy_o;
   endproperty
   property p_ans;
      @(posedge lnk_clk_i) disable iff (rst_i)
      $rose(lnk_busy_o) |-> ##[1:60] lnk_rd_valid_o;
   endproperty
   property p_pulse;
      @(posedge lnk_clk_i) disable iff (rst_i)
      lnk_rd_valid_o |=> !lnk_rd_valid_o;
   endproperty
   a_int: assert property (p_int) else $error("interrupt vs level");
   a_max: assert property (p_max) else $error("level above max");
   a_step: assert property (p_step) else $error("level jump");
   a_ovf_full: assert property (p_ovf_full) else $error("ovf early");
   a_ovf_hold: assert property (p_ovf_hold) else $error("ovf lost");
   a_take: assert property (p_take) else $error("sample not taken");
   a_empty: assert property (p_empty) else $error("empty moved");
   a_busy: assert property (p_busy) else $error("read not taken");
   a_ans: assert property (p_ans) else $error("no read answer");
   a_pulse: assert property (p_pulse) else $error("valid too long");
   c_ovf: cover property (@(posedge clk_i) $rose(overflow_o));
   c_full: cover property (@(posedge clk_i) fifo_fill_level_o == LVL_MAX);
   c_rd: cover property (@(posedge lnk_clk_i) lnk_rd_valid_o);
endmodule : sfr_fifo_properties
bind sfr_fifo_top sfr_fifo_properties #(.RAM_BYTES(RAM_BYTES)) u_chk
   (.clk_i, .rst_i, .clk_en_i, .smp_valid_i, .smp_ready_o,
    .overflow_clear_i, .overflow_o, .fifo_fill_level_o,
    .fifo_data_interrupt_o, .lnk_clk_i, .lnk_addr_set_i, .lnk_rd_i,
    .lnk_rd_valid_o, .lnk_busy_o);
`default_nettype wire

// file: verification/sfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfr_host_model
(
   // Link clock and answers
   input  wire logic       lnk_clk_i,
   input  wire logic [7:0] lnk_rd_data_i,
   input  wire logic       lnk_rd_valid_i,
   input  wire logic       lnk_busy_i,
   // Requests
   output logic            lnk_addr_set_o,
   output logic [7:0]      lnk_addr_o,
   output logic            lnk_rd_o
);
   initial
   begin
      lnk_addr_set_o = 1'b0;
      lnk_addr_o     = 8'h00;
      lnk_rd_o       = 1'b0;
   end
   // one byte read
   // Bursts are just back-to-back calls with no length limit
   task automatic xfer(input logic set, input logic [7:0] a);
      while (lnk_busy_i !== 1'b0)
         @(posedge lnk_clk_i);
      if (set)
      begin
         lnk_addr_set_o <= 1'b1;
         lnk_addr_o     <= a;
         @(posedge lnk_clk_i);
         lnk_addr_set_o <= 1'b0;
         lnk_addr_o     <= ~a; // Released address must not look held
      end
      lnk_rd_o <= 1'b1;
      @(posedge lnk_clk_i);
      lnk_rd_o <= 1'b0;
      do
         @(posedge lnk_clk_i);
      while (lnk_rd_valid_i !== 1'b1);
   endtask : xfer
endmodule : sfr_host_model
`default_nettype wire

// file: verification/spectral_result_fifo_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
module spectral_result_fifo_readout_tb;
   import sfr_pkg::*;
   logic clk_i = 1'b0, lnk_clk_i = 1'b0, rst_i = 1'b1, clk_en_i = 1'b1;
   logic smp_valid_i = 1'b0, status_capture_en_i = 1'b0;
   logic [5:0][15:0] smp_data_i = '0;
   logic [5:0] channel_capture_select_i = '0;
   logic [7:0] analog_status_byte_i = 8'h00, fifo_fill_level_o;
   logic overflow_clear_i = 1'b0, overflow_o, fifo_data_interrupt_o;
   logic smp_ready_o, lnk_addr_set_i, lnk_rd_i, lnk_rd_valid_o, lnk_busy_o;
   logic [7:0] lnk_addr_i, lnk_rd_data_o, ptr = 8'hfe;
   logic [31:0] seed = 32'h000152d6;
   logic [7:0] sb[$], exp_q[$];
   logic ovf = 1'b0;
   int num_errors = 0, cmp_count = 0, cyc = 0, i;
   sfr_fifo_top dut (.clk_i, .rst_i, .clk_en_i, .smp_valid_i, .smp_data_i,
      .channel_capture_select_i, .status_capture_en_i, .analog_status_byte_i,
      .smp_ready_o, .overflow_clear_i, .overflow_o, .fifo_fill_level_o,
      .fifo_data_interrupt_o, .lnk_clk_i, .lnk_addr_set_i, .lnk_addr_i,
      .lnk_rd_i, .lnk_rd_data_o, .lnk_rd_valid_o, .lnk_busy_o);
   sfr_host_model host (.lnk_clk_i, .lnk_rd_data_i(lnk_rd_data_o),
      .lnk_rd_valid_i(lnk_rd_valid_o), .lnk_busy_i(lnk_busy_o),
      .lnk_addr_set_o(lnk_addr_set_i), .lnk_addr_o(lnk_addr_i),
      .lnk_rd_o(lnk_rd_i));
   // Clocks of unrelated periods, the link one offset; their rising edges still meet now and then
   always #25 clk_i = ~clk_i;
   initial #7 forever #32 lnk_clk_i = ~lnk_clk_i;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Core enable stalls about one cycle in four
   always @(posedge clk_i)
      clk_en_i <= (rnd() & 32'h3) != 0;
   task automatic chk(input string n, input logic [7:0] e, s);
      cmp_count++;
      if (s !== e)
      begin
         num_errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic summarize();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : summarize
   // Hang guard
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 40000)
      begin
         num_errors++;
         summarize();
      end
   end
   // Note a byte; a full store drops it and flags overflow
   task automatic note(input logic [7:0] b);
      if (sb.size() < SFR_RAM_BYTES)
         sb.push_back(b);
      else
         ovf = 1'b1;
   endtask : note
   task automatic push(input logic [5:0] sel, input logic st);
      logic [5:0][15:0] d;
      d = {rnd(), rnd(), rnd()};
      for (int c = 0; c < 6; c++)
         if (sel[c])
         begin
            note(d[c][7:0]);
            note(d[c][15:8]);
         end
      if (st)
         note(~d[0][7:0]);
      @(posedge clk_i);
      while (smp_ready_o !== 1'b1)
         @(posedge clk_i);
      smp_valid_i <= 1'b1;
      smp_data_i <= d;
      channel_capture_select_i <= sel;
      status_capture_en_i <= st;
      analog_status_byte_i <= ~d[0][7:0];
      do
         @(posedge clk_i);
      while (!(clk_en_i === 1'b1 && smp_ready_o === 1'b1));
      smp_valid_i <= 1'b0;
   endtask : push
   // Expected byte follows the tracked pointer; a high read pops
   task automatic rd(input logic set, input logic [7:0] a);
      logic [7:0] e;
      if (set)
         ptr = a;
      e = 8'h00;
      if (ptr == SFR_ADDR_LEVEL)
         e = 8'(sb.size() / 2);
      else if (ptr == SFR_ADDR_DATA_LOW && sb.size() > 1)
         e = sb[0];
      else if (ptr == SFR_ADDR_DATA_HIGH && sb.size() > 1)
      begin
         e = sb[1];
         void'(sb.pop_front());
         void'(sb.pop_front());
      end
      exp_q.push_back(e);
      host.xfer(set, a);
      ptr = (ptr == SFR_ADDR_DATA_HIGH) ? SFR_ADDR_DATA_LOW : ptr + 8'h01;
   endtask : rd
   task automatic st(input string t);
      repeat (40) @(posedge clk_i);
      chk("level", 8'(sb.size() / 2), fifo_fill_level_o);
      chk("interrupt", 8'(sb.size() > 1), 8'(fifo_data_interrupt_o));
      chk("overflow", 8'(ovf), 8'(overflow_o));
      $display("test %s done", t);
   endtask : st
   // Read answers are matched against the oldest queued expectation
   always @(posedge lnk_clk_i)
      if (lnk_rd_valid_o === 1'b1)
      begin
         if (exp_q.size() > 0)
            chk("read data", exp_q.pop_front(), lnk_rd_data_o);
         else
            chk("spare answer", 8'h00, 8'h01);
      end
   initial
   begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      st("reset");
      for (i = 0; i < 3; i++)
         rd(i == 0, SFR_ADDR_DATA_LOW);
      st("empty");
      for (i = 0; i < 6; i++)
         push(6'(rnd()), 1'(rnd()));
      st("push");
      rd(1, SFR_ADDR_LEVEL);
      for (i = 0; i < 50; i++)
         rd(i == 0, SFR_ADDR_DATA_LOW);
      st("burst");
      push(6'h3f, 1'b1);
      for (i = 0; i < 12; i++)
         rd(1, (i % 3 == 2) ? SFR_ADDR_DATA_HIGH : SFR_ADDR_DATA_LOW);
      rd(1, 8'h10);
      st("single");
      for (i = 0; i < 22; i++)
         push(6'h3f, 1'b0);
      st("overflow");
      @(posedge clk_i);
      overflow_clear_i <= 1'b1;
      // Hold the clear until an edge with the core enabled has seen it
      do
         @(posedge clk_i);
      while (clk_en_i !== 1'b1);
      overflow_clear_i <= 1'b0;
      ovf = 1'b0;
      for (i = 0; i < 260; i++)
         rd(i == 0, SFR_ADDR_DATA_LOW);
      st("drain");
      summarize();
   end
endmodule : spectral_result_fifo_readout_tb
`default_nettype wire
